// ==== alsrd_host.sv ====
// host-side model issuing byte-level register transfers
`timescale 1ns/1ps
module alsrd_host (
    input  wire logic                 i_clk,
    input  wire logic [7:0]           i_bus_rdata,
    output alsrd_pkg::alsrd_bus_req_t o_bus_req
);
    initial o_bus_req = '0;
    // ==========================================================
    // one request per call, raised and dropped on falling edges
    task automatic pulse(input logic wr, rd, rs, st,
                         input logic [7:0] a, d);
        @(negedge i_clk);
        o_bus_req = '{wr, rd, rs, st, a, d};
        @(negedge i_clk);
        // released fields show the inverse, never a stale copy
        o_bus_req = '{1'b0, 1'b0, 1'b0, 1'b0, ~a, ~d};
    endtask
    // ==========================================================
    // whole transactions
    task automatic wr_reg(input logic [7:0] a, d);
        pulse(1'b1, 1'b0, 1'b0, 1'b0, a, d);
        pulse(1'b0, 1'b0, 1'b0, 1'b1, a, d);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        pulse(1'b0, 1'b0, 1'b1, 1'b0, a, 8'h00);
        pulse(1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00);
        @(negedge i_clk);
        d = i_bus_rdata;
        pulse(1'b0, 1'b0, 1'b0, 1'b1, a, 8'h00);
    endtask
endmodule

// ==== alsrd_pkg.sv ====
// package: constants and types for the light sequencer and result readout
package alsrd_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_LO_TH_HI   = 8'h22;
    localparam logic [7:0] OFS_LO_TH_LO   = 8'h23;
    localparam logic [7:0] OFS_SENS_CFG   = 8'h25;
    localparam logic [7:0] OFS_INTERVAL   = 8'h26;
    localparam logic [7:0] OFS_CONTROL    = 8'h27;
    localparam logic [7:0] OFS_INT_STATUS = 8'h40;
    localparam logic [7:0] OFS_PROX_HI    = 8'h41;
    localparam logic [7:0] OFS_PROX_LO    = 8'h42;
    localparam logic [7:0] OFS_LIGHT_HI   = 8'h43;
    localparam logic [7:0] OFS_LIGHT_LO   = 8'h44;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_LO_TH      = 8'h00;
    localparam logic [5:0] RST_SENS_CFG   = 6'h04;
    localparam logic [5:0] RST_INTERVAL   = 6'h0a;
    localparam logic [1:0] RST_CONTROL    = 2'h0;
    localparam logic [15:0] RST_RESULT    = 16'h0000;
    // ==========================================================
    // field positions
    localparam int SENS_CODE_MSB  = 2;
    localparam int HYST_EN_BIT    = 5;
    localparam int HYST_SIDE_BIT  = 4;
    localparam int CTRL_SINGLE    = 0;
    localparam int CTRL_REPEAT    = 1;
    localparam int STAT_INT_BIT   = 4;
    localparam int STAT_L_ABOVE   = 3;
    localparam int STAT_L_BELOW   = 2;
    localparam int STAT_P_ABOVE   = 1;
    localparam int STAT_P_BELOW   = 0;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS    = 50;
    localparam int INTEG_BASE_NS    = 6250000;
    localparam int INTERVAL_UNIT_NS = 50000000;
    localparam int SHORT_GAP_NS     = 10000000;
    localparam int CONT_GAP_NS      = 5000;
    localparam int INTEG_BASE_CYC    = INTEG_BASE_NS / CLK_PERIOD_NS;
    localparam int INTERVAL_UNIT_CYC = INTERVAL_UNIT_NS / CLK_PERIOD_NS;
    localparam int SHORT_GAP_CYC     = SHORT_GAP_NS / CLK_PERIOD_NS;
    localparam int CONT_GAP_CYC      = CONT_GAP_NS / CLK_PERIOD_NS;
    // ==========================================================
    // types
    typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_GAP} alsrd_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       rd_start;
        logic       stop;
        logic [7:0] addr;
        logic [7:0] wdata;
    } alsrd_bus_req_t;
endpackage

// ==== alsrd_top.sv ====
// module: light measurement sequencer, interrupt status and result readout
// Behaviour
// - 16-bit lower light threshold, two bytes, reset zero
// - 3-bit code doubles measure time, reset 100ms
// - config bit 5 enables threshold hysteresis
// - config bit 4 picks hysteresis threshold side
// - interval field counts 50 ms, reset 0x0A
// - zero interval runs measurements back to back
// - control bit 1 starts repeated measurements
// - control bit 0 single measurement, self-clears
// - sensor powered off after single measurements and before long gaps
// - status bit 4 mirrors interrupt pin
// - status bits 3,2 light above/below
// - status bits 1,0 proximity above/below
// - status read clears when auto-clear off
// - proximity result high byte then low
// - light result high byte then low
// - results frozen from read start to stop
// - no hysteresis: outside window raises interrupt
// - hysteresis set/clear, only in auto-clear
// - stop after control write starts sequencer
// - short gaps 5us or 10ms, power on
`timescale 1ns/1ps
module alsrd_top #(
    parameter int INTEG_BASE_CYC    = alsrd_pkg::INTEG_BASE_CYC,
    parameter int INTERVAL_UNIT_CYC = alsrd_pkg::INTERVAL_UNIT_CYC,
    parameter int SHORT_GAP_CYC     = alsrd_pkg::SHORT_GAP_CYC
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    input  wire alsrd_pkg::alsrd_bus_req_t i_bus_req,
    input  wire logic                      i_auto_clear,
    input  wire logic [15:0]               i_light_high_threshold,
    input  wire logic [15:0]               i_light_count,
    input  wire logic                      i_prox_valid,
    input  wire logic [15:0]               i_prox_value,
    input  wire logic                      i_prox_above,
    input  wire logic                      i_prox_below,
    output logic      [7:0]                o_bus_rdata,
    output logic                           o_int,
    output logic                           o_light_power
);
    default clocking chk_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    // ==========================================================
    // registers
    logic [15:0]             lo_th_ff;
    logic [5:0]              cfg_ff;
    logic [5:0]              intv_ff;
    logic [1:0]              ctrl_ff;
    logic [3:0]              flags_ff;
    logic [15:0]             light_res_ff;
    logic [15:0]             prox_res_ff;
    logic [15:0]             light_pend_ff;
    logic [15:0]             prox_pend_ff;
    logic                    light_upd_ff;
    logic                    prox_upd_ff;
    logic                    locked_ff;
    logic                    ctrl_wr_ff;
    logic [31:0]             cnt_ff;
    alsrd_pkg::alsrd_state_t state_ff;
    alsrd_pkg::alsrd_state_t nxt_state;
    logic [31:0]             nxt_cnt;
    logic [3:0]              nxt_flags;

    // ==========================================================
    // decode
    wire wr_lo_hi  = i_bus_req.wr && i_bus_req.addr == alsrd_pkg::OFS_LO_TH_HI;
    wire wr_lo_lo  = i_bus_req.wr && i_bus_req.addr == alsrd_pkg::OFS_LO_TH_LO;
    wire wr_cfg    = i_bus_req.wr && i_bus_req.addr == alsrd_pkg::OFS_SENS_CFG;
    wire wr_intv   = i_bus_req.wr && i_bus_req.addr == alsrd_pkg::OFS_INTERVAL;
    wire wr_ctrl   = i_bus_req.wr && i_bus_req.addr == alsrd_pkg::OFS_CONTROL;
    wire rd_status = i_bus_req.rd
                     && i_bus_req.addr == alsrd_pkg::OFS_INT_STATUS;

    wire [2:0]  sens_code = cfg_ff[alsrd_pkg::SENS_CODE_MSB:0];
    wire        hyst_en   = cfg_ff[alsrd_pkg::HYST_EN_BIT];
    wire        hyst_side = cfg_ff[alsrd_pkg::HYST_SIDE_BIT];
    wire        run_rep   = ctrl_ff[alsrd_pkg::CTRL_REPEAT];
    wire        run_one   = ctrl_ff[alsrd_pkg::CTRL_SINGLE];
    // duration doubles per code
    wire [31:0] dur_cyc   = 32'(INTEG_BASE_CYC) << sens_code;
    // 50 ms per interval count
    wire [31:0] intv_cyc  = 32'(intv_ff) * 32'(INTERVAL_UNIT_CYC);
    wire        intv_zero = intv_ff == 6'h00;
    wire        long_gap  = intv_cyc > dur_cyc;
    wire        meas_done = state_ff == alsrd_pkg::ST_INTEG
                            && cnt_ff == 32'h0000_0000;
    wire        gap_done  = state_ff == alsrd_pkg::ST_GAP
                            && cnt_ff == 32'h0000_0000;
    // stop after a control write wakes the sequencer
    wire        kick      = ctrl_wr_ff && i_bus_req.stop
                            && state_ff == alsrd_pkg::ST_IDLE
                            && (run_rep || run_one);
    // zero interval: 5us, short interval: 10ms, else the interval
    wire [31:0] gap_cyc   = intv_zero ? 32'(alsrd_pkg::CONT_GAP_CYC)
                          : (long_gap ? intv_cyc : 32'(SHORT_GAP_CYC));
    wire        above_hit = i_light_count > i_light_high_threshold;
    wire        below_hit = i_light_count < lo_th_ff;
    wire        unlocked  = !locked_ff || i_bus_req.stop;

    // ==========================================================
    // sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff - 32'h0000_0001;
        case (state_ff)
            alsrd_pkg::ST_IDLE: begin
                nxt_cnt = 32'h0000_0000;
                if (kick) begin
                    nxt_state = alsrd_pkg::ST_INTEG;
                    nxt_cnt   = dur_cyc - 32'h0000_0001;
                end
            end
            alsrd_pkg::ST_INTEG: begin
                if (meas_done) begin
                    // repeat wins when both bits are set
                    if (run_rep) begin
                        nxt_state = alsrd_pkg::ST_GAP;
                        nxt_cnt   = gap_cyc - 32'h0000_0001;
                    end else begin
                        nxt_state = alsrd_pkg::ST_IDLE;
                        nxt_cnt   = 32'h0000_0000;
                    end
                end
            end
            alsrd_pkg::ST_GAP: begin
                if (!run_rep) begin
                    nxt_state = alsrd_pkg::ST_IDLE;
                    nxt_cnt   = 32'h0000_0000;
                end else if (gap_done) begin
                    nxt_state = alsrd_pkg::ST_INTEG;
                    nxt_cnt   = dur_cyc - 32'h0000_0001;
                end
            end
            default: begin
                nxt_state = alsrd_pkg::ST_IDLE;
                nxt_cnt   = 32'h0000_0000;
            end
        endcase
    end

    // power held only through integration and short gaps
    wire nxt_power = nxt_state == alsrd_pkg::ST_INTEG
                     || (nxt_state == alsrd_pkg::ST_GAP && !long_gap);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff      <= alsrd_pkg::ST_IDLE;
            cnt_ff        <= 32'h0000_0000;
            o_light_power <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            o_light_power <= nxt_power;
        end
    end

    // ==========================================================
    // configuration registers
    // software write in the same cycle wins over the self-clear
    wire [1:0] nxt_ctrl = wr_ctrl ? i_bus_req.wdata[1:0]
                        : (meas_done ? (ctrl_ff & 2'h2) : ctrl_ff);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lo_th_ff   <= {alsrd_pkg::RST_LO_TH, alsrd_pkg::RST_LO_TH};
            cfg_ff     <= alsrd_pkg::RST_SENS_CFG;
            intv_ff    <= alsrd_pkg::RST_INTERVAL;
            ctrl_ff    <= alsrd_pkg::RST_CONTROL;
            ctrl_wr_ff <= 1'b0;
        end else begin
            if (wr_lo_hi) lo_th_ff[15:8] <= i_bus_req.wdata;
            if (wr_lo_lo) lo_th_ff[7:0]  <= i_bus_req.wdata;
            if (wr_cfg)   cfg_ff  <= i_bus_req.wdata[5:0];
            if (wr_intv)  intv_ff <= i_bus_req.wdata[5:0];
            ctrl_ff    <= nxt_ctrl;
            // armed by a control write, consumed by the stop
            ctrl_wr_ff <= wr_ctrl || (ctrl_wr_ff && !i_bus_req.stop);
        end
    end

    // ==========================================================
    // interrupt flags: {light above, light below, prox above, prox below}
    always_comb begin
        nxt_flags = flags_ff;
        if (rd_status && !i_auto_clear) begin
            nxt_flags = 4'h0;
        end
        if (meas_done) begin
            if (!i_auto_clear) begin
                nxt_flags[3] = nxt_flags[3] | above_hit;
                nxt_flags[2] = nxt_flags[2] | below_hit;
            end else if (!hyst_en) begin
                nxt_flags[3] = above_hit;
                nxt_flags[2] = below_hit;
            end else if (hyst_side) begin
                // upper sets, lower clears
                nxt_flags[3] = above_hit | (flags_ff[3] & !below_hit);
                nxt_flags[2] = 1'b0;
            end else begin
                nxt_flags[2] = below_hit | (flags_ff[2] & !above_hit);
                nxt_flags[3] = 1'b0;
            end
        end
        if (i_prox_valid) begin
            if (i_auto_clear) begin
                nxt_flags[1:0] = {i_prox_above, i_prox_below};
            end else begin
                nxt_flags[1:0] = nxt_flags[1:0]
                                 | {i_prox_above, i_prox_below};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flags_ff <= 4'h0;
            o_int    <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            o_int    <= |nxt_flags;
        end
    end

    // ==========================================================
    // result registers with read lock
    // a result landing during a locked read waits for the stop
    wire [15:0] light_new = meas_done ? i_light_count : light_pend_ff;
    wire        light_has = meas_done || light_upd_ff;
    wire [15:0] prox_new  = i_prox_valid ? i_prox_value : prox_pend_ff;
    wire        prox_has  = i_prox_valid || prox_upd_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            light_res_ff  <= alsrd_pkg::RST_RESULT;
            prox_res_ff   <= alsrd_pkg::RST_RESULT;
            light_pend_ff <= alsrd_pkg::RST_RESULT;
            prox_pend_ff  <= alsrd_pkg::RST_RESULT;
            light_upd_ff  <= 1'b0;
            prox_upd_ff   <= 1'b0;
            locked_ff     <= 1'b0;
        end else begin
            light_pend_ff <= light_new;
            prox_pend_ff  <= prox_new;
            light_upd_ff  <= light_has && !unlocked;
            prox_upd_ff   <= prox_has && !unlocked;
            if (light_has && unlocked) light_res_ff <= light_new;
            if (prox_has && unlocked)  prox_res_ff  <= prox_new;
            if (i_bus_req.rd_start) begin
                locked_ff <= 1'b1;
            end else if (i_bus_req.stop) begin
                locked_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // read data
    wire [7:0] status_byte = {3'h0, o_int, flags_ff};
    logic [7:0] rd_mux;
    always_comb begin
        if (i_bus_req.addr == alsrd_pkg::OFS_LO_TH_HI) begin
            rd_mux = lo_th_ff[15:8];
        end else if (i_bus_req.addr == alsrd_pkg::OFS_LO_TH_LO) begin
            rd_mux = lo_th_ff[7:0];
        end else if (i_bus_req.addr == alsrd_pkg::OFS_SENS_CFG) begin
            rd_mux = {2'h0, cfg_ff};
        end else if (i_bus_req.addr == alsrd_pkg::OFS_INTERVAL) begin
            rd_mux = {2'h0, intv_ff};
        end else if (i_bus_req.addr == alsrd_pkg::OFS_CONTROL) begin
            rd_mux = {6'h00, ctrl_ff};
        end else if (i_bus_req.addr == alsrd_pkg::OFS_INT_STATUS) begin
            rd_mux = status_byte;
        end else if (i_bus_req.addr == alsrd_pkg::OFS_PROX_HI) begin
            rd_mux = prox_res_ff[15:8];
        end else if (i_bus_req.addr == alsrd_pkg::OFS_PROX_LO) begin
            rd_mux = prox_res_ff[7:0];
        end else if (i_bus_req.addr == alsrd_pkg::OFS_LIGHT_HI) begin
            rd_mux = light_res_ff[15:8];
        end else if (i_bus_req.addr == alsrd_pkg::OFS_LIGHT_LO) begin
            rd_mux = light_res_ff[7:0];
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_rdata <= 8'h00;
        end else if (i_bus_req.rd) begin
            o_bus_rdata <= rd_mux;
        end
    end

    // ==========================================================
    // checks
    chk_single_clear: assert property (
        meas_done && !wr_ctrl |=> !ctrl_ff[alsrd_pkg::CTRL_SINGLE])
        else $error("single bit not cleared after measurement");
    chk_power_drop: assert property (
        meas_done && (!run_rep || long_gap) |=> !o_light_power)
        else $error("sensor power stayed on after measurement");
    chk_short_gap_pwr: assert property (
        meas_done && run_rep && intv_zero |=> o_light_power [*3])
        else $error("power dropped in continuous gap");
    chk_cont_gap_len: assert property (
        $rose(state_ff == alsrd_pkg::ST_GAP) && intv_zero
        |-> ##[1:101] state_ff != alsrd_pkg::ST_GAP)
        else $error("continuous gap too long");
    chk_result_frozen: assert property (
        locked_ff && !i_bus_req.stop |=> $stable(light_res_ff)
        && $stable(prox_res_ff))
        else $error("result changed during read");
    chk_read_clear: assert property (
        rd_status && !i_auto_clear && !meas_done && !i_prox_valid
        |=> flags_ff == 4'h0 && !o_int)
        else $error("status read did not clear interrupt");
    chk_stop_start: assert property (
        kick |=> state_ff == alsrd_pkg::ST_INTEG && o_light_power)
        else $error("stop did not start measurement");
    chk_window_flag: assert property (
        meas_done && !hyst_en && above_hit |=> flags_ff[3] && o_int)
        else $error("above-window result not flagged");
    chk_int_status: assert property (
        rd_status |=> o_bus_rdata[alsrd_pkg::STAT_INT_BIT] == $past(o_int))
        else $error("status bit 4 differs from pin");
    chk_repeat_wins: assert property (
        meas_done && run_rep && run_one && !wr_ctrl
        |=> state_ff == alsrd_pkg::ST_GAP && ctrl_ff == 2'h2)
        else $error("repeat did not take priority");
    cov_single: cover property (
        kick && !run_rep ##[1:1000] meas_done);
    cov_repeat: cover property (
        gap_done && run_rep);
    cov_locked_meas: cover property (
        locked_ff && meas_done);
endmodule

// ==== alsrd_top_test.sv ====
// self-checking bench for the light sequencer and readout
`timescale 1ns/1ps
module alsrd_top_test;
    localparam int BASE = 8;
    localparam int UNIT = 40;
    localparam logic [15:0] LO_TH = 16'h1000;
    localparam logic [7:0] RA [11] = '{8'h22, 8'h23, 8'h25, 8'h26,
        8'h27, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h30};
    localparam logic [7:0] RD [11] = '{8'h00, 8'h00, 8'h04, 8'h0a,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] WA [5] = '{8'h22, 8'h23, 8'h25, 8'h26, 8'h43};
    localparam logic [7:0] WM [5] = '{8'hff, 8'hff, 8'h3f, 8'h3f, 8'h00};
    logic        i_clk    = 1'b0;
    logic        i_rst_b  = 1'b0;
    logic        auto_clr = 1'b0;
    logic [15:0] hi_th    = 16'hf000;
    logic [15:0] lcount   = 16'h0000;
    logic        p_vld    = 1'b0;
    logic [15:0] p_val    = 16'h0000;
    logic        p_abv    = 1'b0;
    logic        p_blw    = 1'b0;
    logic [7:0]  rdata;
    logic        int_pin;
    logic        pwr;
    logic [7:0]  v;
    logic [15:0] c;
    int          n;
    int          mismatches = 0;
    int          num_checks = 0;
    int          seed       = 32'hd2c7_a8e1;
    alsrd_pkg::alsrd_bus_req_t req;
    always #25 i_clk = ~i_clk;
    alsrd_host host (.i_clk(i_clk), .i_bus_rdata(rdata), .o_bus_req(req));
    alsrd_top #(.INTEG_BASE_CYC(BASE), .INTERVAL_UNIT_CYC(UNIT),
                .SHORT_GAP_CYC(20)) dut (
        .i_clk                  (i_clk),
        .i_rst_b                (i_rst_b),
        .i_bus_req              (req),
        .i_auto_clear           (auto_clr),
        .i_light_high_threshold (hi_th),
        .i_light_count          (lcount),
        .i_prox_valid           (p_vld),
        .i_prox_value           (p_val),
        .i_prox_above           (p_abv),
        .i_prox_below           (p_blw),
        .o_bus_rdata            (rdata),
        .o_int                  (int_pin),
        .o_light_power          (pwr)
    );
    // ==========================================================
    // expectations and helpers
    function automatic logic [1:0] win(input logic [15:0] x);
        return {x > hi_th, x < LO_TH};
    endfunction
    function automatic logic [7:0] stat(input logic [1:0] f);
        return {3'b000, |f, f, 2'b00};
    endfunction
    // kind 0 below window, 1 inside, 2 above
    function automatic logic [15:0] pick(input int kind);
        logic [15:0] r;
        r = 16'($random(seed));
        if (kind == 0) return {4'h0, r[11:0]};
        if (kind == 1) return {4'h2, r[11:0]};
        return {8'hf1, r[7:0]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic creg(input logic [7:0] a, exp);
        host.rd_reg(a, v);
        check($sformatf("reg %h", a), {8'h00, v}, {8'h00, exp});
    endtask
    // bounded wait; counts falling edges until power reaches lvl
    task automatic wait_pwr(input logic lvl);
        n = 0;
        while (pwr !== lvl && n < 5000) begin
            @(negedge i_clk);
            n++;
        end
        check("power level", {15'h0, pwr}, {15'h0, lvl});
    endtask
    task automatic measure(input logic [15:0] x);
        lcount = x;
        host.wr_reg(alsrd_pkg::OFS_CONTROL, 8'h01);
        wait_pwr(1'b1);
        wait_pwr(1'b0);
    endtask
    task automatic conclude();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(90000 * 50);
        mismatches++;
        conclude();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(negedge i_clk);
        i_rst_b = 1'b1;
        for (int i = 0; i < 11; i++) begin
            creg(RA[i], RD[i]);
        end
        for (int i = 0; i < 5; i++) begin
            v = 8'($random(seed));
            host.wr_reg(WA[i], v);
            creg(WA[i], v & WM[i]);
        end
        host.wr_reg(8'h22, 8'h10);
        host.wr_reg(8'h23, 8'h00);
        // short codes only to keep the run brief
        for (int k = 0; k < 4; k++) begin
            host.wr_reg(alsrd_pkg::OFS_SENS_CFG, 8'(k));
            lcount = pick(1);
            host.wr_reg(alsrd_pkg::OFS_CONTROL, 8'h01);
            wait_pwr(1'b1);
            wait_pwr(1'b0);
            check("integ cycles", 16'(n), 16'(BASE << k));
        end
        creg(alsrd_pkg::OFS_CONTROL, 8'h00);
        host.wr_reg(alsrd_pkg::OFS_SENS_CFG, 8'h00);
        for (int k = 0; k < 3; k += 2) begin
            c = pick(k);
            measure(c);
            creg(alsrd_pkg::OFS_LIGHT_HI, c[15:8]);
            creg(alsrd_pkg::OFS_LIGHT_LO, c[7:0]);
            check("int pin", {15'h0, int_pin}, 16'h0001);
            creg(alsrd_pkg::OFS_INT_STATUS, stat(win(c)));
            check("int clear", {15'h0, int_pin}, 16'h0000);
            creg(alsrd_pkg::OFS_INT_STATUS, 8'h00);
        end
        for (int k = 0; k < 2; k++) begin
            p_val = 16'($random(seed));
            p_abv = (k == 0);
            p_blw = (k == 1);
            p_vld = 1'b1;
            @(negedge i_clk);
            p_vld = 1'b0;
            creg(alsrd_pkg::OFS_PROX_HI, p_val[15:8]);
            creg(alsrd_pkg::OFS_PROX_LO, p_val[7:0]);
            creg(alsrd_pkg::OFS_INT_STATUS, k ? 8'h11 : 8'h12);
            creg(alsrd_pkg::OFS_INT_STATUS, 8'h00);
        end
        // a result finishing during a locked read must not show
        c = lcount;
        lcount = pick(1);
        host.wr_reg(alsrd_pkg::OFS_CONTROL, 8'h01);
        host.pulse(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
        wait_pwr(1'b1);
        wait_pwr(1'b0);
        host.pulse(1'b0, 1'b1, 1'b0, 1'b0, alsrd_pkg::OFS_LIGHT_LO, 8'h00);
        @(negedge i_clk);
        check("locked result", {8'h00, rdata}, {8'h00, c[7:0]});
        host.pulse(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
        creg(alsrd_pkg::OFS_LIGHT_LO, lcount[7:0]);
        auto_clr = 1'b1;
        measure(pick(2));
        creg(alsrd_pkg::OFS_INT_STATUS, 8'h18);
        measure(pick(1));
        creg(alsrd_pkg::OFS_INT_STATUS, 8'h00);
        for (int s = 0; s < 2; s++) begin
            host.wr_reg(alsrd_pkg::OFS_SENS_CFG, s ? 8'h30 : 8'h20);
            for (int j = 0; j < 3; j++) begin
                measure(pick(s ? 2 - j : j));
                v = j < 2 ? (s ? 8'h18 : 8'h14) : 8'h00;
                creg(alsrd_pkg::OFS_INT_STATUS, v);
            end
        end
        auto_clr = 1'b0;
        host.wr_reg(alsrd_pkg::OFS_SENS_CFG, 8'h00);
        host.wr_reg(alsrd_pkg::OFS_INTERVAL, 8'h03);
        lcount = pick(1);
        host.wr_reg(alsrd_pkg::OFS_CONTROL, 8'h02);
        wait_pwr(1'b1);
        wait_pwr(1'b0);
        wait_pwr(1'b1);
        check("interval gap", 16'(n), 16'(3 * UNIT));
        for (int k = 0; k < 2; k++) begin
            host.wr_reg(alsrd_pkg::OFS_INTERVAL, 8'(k));
            host.wr_reg(alsrd_pkg::OFS_SENS_CFG, 8'(3 * k));
            repeat (200) @(negedge i_clk);
            n = 0;
            repeat (300) begin
                @(negedge i_clk);
                n += (pwr !== 1'b1);
            end
            check("power drops", 16'(n), 16'h0000);
        end
        host.wr_reg(alsrd_pkg::OFS_CONTROL, 8'h00);
        host.wr_reg(alsrd_pkg::OFS_INTERVAL, 8'h03);
        host.wr_reg(alsrd_pkg::OFS_SENS_CFG, 8'h00);
        repeat (300) @(negedge i_clk);
        check("idle power", {15'h0, pwr}, 16'h0000);
        host.wr_reg(alsrd_pkg::OFS_CONTROL, 8'h03);
        wait_pwr(1'b1);
        wait_pwr(1'b0);
        creg(alsrd_pkg::OFS_CONTROL, 8'h02);
        wait_pwr(1'b1);
        host.wr_reg(alsrd_pkg::OFS_CONTROL, 8'h00);
        conclude();
    end
endmodule
